// ---- logic/aphc_defines.svh ----
`ifndef APHC_DEFINES_SVH
`define APHC_DEFINES_SVH
// number of hit counters
`define APHC_NUM_CNT 4
// width of a match address (covers the full code space)
`define APHC_ADDR_W 15
// width of a count value
`define APHC_CNT_W 16
// width of a counter index
`define APHC_IDX_W 2
// reset value of a count
`define APHC_CNT_RST 16'h0000
// reset value of a match address
`define APHC_ADDR_RST 15'h0000
// index of the counter that owns the overflow break
`define APHC_BRK_IDX 2'h0
`endif

// ---- logic/aphc_pkg.sv ----
`include "aphc_defines.svh"
package aphc_pkg;
    // one counter as seen by the host
    typedef struct packed {
        logic [`APHC_ADDR_W-1:0] addr;
        logic [`APHC_CNT_W-1:0] count;
        logic ovf;
    } aphc_entry_t;
    // host write command
    typedef struct packed {
        logic valid;
        logic [`APHC_IDX_W-1:0] idx;
        logic addr_given;
        logic [`APHC_ADDR_W-1:0] addr;
        logic count_given;
        logic [`APHC_CNT_W-1:0] count;
    } aphc_wr_t;
    // executed instruction report from the core
    typedef struct packed {
        logic valid;
        logic [`APHC_ADDR_W-1:0] addr;
    } aphc_exec_t;
endpackage : aphc_pkg

// ---- logic/aphc_counter.sv ----
`include "aphc_defines.svh"
// one hit counter: match address, count and overflow flag
module aphc_counter
    import aphc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic wr_addr_given_i,
    input wire logic [`APHC_ADDR_W-1:0] wr_addr_i,
    input wire logic wr_count_given_i,
    input wire logic [`APHC_CNT_W-1:0] wr_count_i,
    input wire logic hit_i,
    output aphc_entry_t entry_o,
    output logic wrap_o
);
    // registered state of the counter
    aphc_entry_t st_q;
    aphc_entry_t st_d;
    logic [`APHC_CNT_W:0] sum;

    // next state: a load beats a hit in the same cycle
    always_comb
    begin
        st_d = st_q;
        sum = {1'b0, st_q.count} + {{`APHC_CNT_W{1'b0}}, 1'b1};
        wrap_o = 1'b0;
        if (wr_i)
        begin
            // keep old address unless a new one is given
            if (wr_addr_given_i)
            begin
                st_d.addr = wr_addr_i;
            end
            // missing count loads zero
            st_d.count = wr_count_given_i ? wr_count_i : `APHC_CNT_RST;
            st_d.ovf = 1'b0;
        end
        else if (hit_i)
        begin
            // one step per executed match
            st_d.count = sum[`APHC_CNT_W-1:0];
            if (sum[`APHC_CNT_W])
            begin
                st_d.ovf = 1'b1;
                wrap_o = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q <= '{addr: `APHC_ADDR_RST, count: `APHC_CNT_RST, ovf: 1'b0};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign entry_o = st_q;

    chk_load_zero_count: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_i && !wr_count_given_i |=> entry_o.count == `APHC_CNT_RST && !entry_o.ovf)
        else $error("count not zero after load without count");
    chk_keep_match_addr: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_i && !wr_addr_given_i |=> $stable(entry_o.addr))
        else $error("match address changed without new address");
    chk_hit_increment: assert property (@(posedge mclk_i) disable iff (rst_i)
        !wr_i && hit_i |=> entry_o.count == $past(entry_o.count) + 16'h0001)
        else $error("count did not step on a hit");
    chk_wrap_sets_ovf: assert property (@(posedge mclk_i) disable iff (rst_i)
        !wr_i && hit_i && entry_o.count == 16'hffff |=> entry_o.ovf && entry_o.count == 16'h0000)
        else $error("wrap did not set overflow");
endmodule : aphc_counter

// ---- logic/aphc_top.sv ----
`include "aphc_defines.svh"
module aphc_top
    import aphc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic emu_run_i,
    input aphc_exec_t exec_i,
    input aphc_wr_t wr_i,
    input wire logic ovf_break_sel_i,
    input wire logic rd_i,
    input wire logic rd_all_i,
    input wire logic [`APHC_IDX_W-1:0] rd_idx_i,
    output aphc_entry_t rd_entry_o,
    output aphc_entry_t [`APHC_NUM_CNT-1:0] rd_all_o,
    output logic rd_valid_o,
    output logic break_o
);
    // registered read port and break request
    typedef struct packed {
        aphc_entry_t rd_entry;
        aphc_entry_t [`APHC_NUM_CNT-1:0] rd_all;
        logic rd_valid;
        logic brk;
    } aphc_top_st_t;

    aphc_top_st_t st_q;
    aphc_top_st_t st_d;
    aphc_entry_t [`APHC_NUM_CNT-1:0] entries; // live counter contents
    logic [`APHC_NUM_CNT-1:0] wraps; // one-cycle wrap pulses

    // one counter per index
    generate
        for (genvar i = 0; i < `APHC_NUM_CNT; i++)
        begin : g_cnt
            aphc_counter u_cnt (
                .mclk_i(mclk_i),
                .rst_i(rst_i),
                .wr_i(wr_i.valid && wr_i.idx == `APHC_IDX_W'(i)),
                .wr_addr_given_i(wr_i.addr_given),
                .wr_addr_i(wr_i.addr),
                .wr_count_given_i(wr_i.count_given),
                .wr_count_i(wr_i.count),
                .hit_i(emu_run_i && exec_i.valid && exec_i.addr == entries[i].addr),
                .entry_o(entries[i]),
                .wrap_o(wraps[i])
            );
        end
    endgenerate

    // read capture and break decision
    always_comb
    begin
        st_d = st_q;
        st_d.rd_valid = rd_i;
        if (rd_i)
        begin
            // selected one always, plus all four when rd_all_i is set
            st_d.rd_entry = entries[rd_idx_i];
            st_d.rd_all = rd_all_i ? entries : '0;
        end
        // only counter zero may break; held until emulation stops
        if (ovf_break_sel_i && wraps[`APHC_BRK_IDX])
        begin
            st_d.brk = 1'b1;
        end
        else if (!emu_run_i)
        begin
            st_d.brk = 1'b0;
        end
    end

    // state register
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign rd_entry_o = st_q.rd_entry;
    assign rd_all_o = st_q.rd_all;
    assign rd_valid_o = st_q.rd_valid;
    // break shows in the very cycle of the wrap
    assign break_o = st_q.brk || (ovf_break_sel_i && wraps[`APHC_BRK_IDX]);

    chk_break_on_wrap: assert property (@(posedge mclk_i) disable iff (rst_i)
        ovf_break_sel_i && wraps[`APHC_BRK_IDX] |-> break_o ##1 (break_o || !emu_run_i))
        else $error("overflow did not halt emulation");
    chk_no_break_unsel: assert property (@(posedge mclk_i) disable iff (rst_i)
        !st_q.brk && !(ovf_break_sel_i && wraps[`APHC_BRK_IDX]) |-> !break_o)
        else $error("break without selected overflow");
    // a held break drops once emulation has stopped
    chk_break_release: assert property (@(posedge mclk_i) disable iff (rst_i)
        !emu_run_i && !(ovf_break_sel_i && wraps[`APHC_BRK_IDX]) |=> !st_q.brk)
        else $error("break held after emulation stopped");
    // a read of one counter leaves the all-counters vector empty
    chk_read_one_only: assert property (@(posedge mclk_i) disable iff (rst_i)
        rd_i && !rd_all_i |=> rd_all_o == '0)
        else $error("read of one counter returned the whole set");
    chk_read_selected: assert property (@(posedge mclk_i) disable iff (rst_i)
        rd_i |=> rd_valid_o && rd_entry_o == $past(entries[rd_idx_i]))
        else $error("read returned wrong counter");
    chk_read_all: assert property (@(posedge mclk_i) disable iff (rst_i)
        rd_i && rd_all_i |=> rd_all_o == $past(entries))
        else $error("read all returned wrong set");
endmodule : aphc_top

// ---- test/aphc_core_model.sv ----
`include "aphc_defines.svh"
// core side: runs one address repeatedly and halts on a break request
module aphc_core_model
    import aphc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic break_i,
    output logic emu_run_o,
    output aphc_exec_t exec_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic broke = 1'b0; // last run was halted by a break
    initial
    begin
        emu_run_o = 1'b0;
        exec_o = '0;
    end
    // execute address a up to n times, stop once break is seen
    task automatic run(input logic [14:0] a, input int n);
        logic stop;
        broke = 1'b0;
        emu_run_o = 1'b1;
        exec_o.addr = a;
        for (int i = 0; i < n; i++)
        begin
            exec_o.valid = 1'b1;
            @(posedge mclk_i);
            #1;
            // look once the edge has settled, not in its own time step
            stop = (break_i === 1'b1);
            if (stop)
            begin
                broke = 1'b1;
                break;
            end
        end
        // idle bus shows a changed address, not the last one
        exec_o = {1'b0, ~a};
        emu_run_o = 1'b0;
    endtask : run
endmodule : aphc_core_model

// ---- test/address_pass_counters_bench.sv ----
`include "aphc_defines.svh"
module address_pass_counters_bench
    import aphc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic run;
    aphc_exec_t exe;
    aphc_wr_t wr = '0;
    logic sel = 1'b0;
    logic rd = 1'b0;
    logic rd_all = 1'b0;
    logic [1:0] idx = 2'h0;
    aphc_entry_t ent;
    aphc_entry_t [3:0] all;
    aphc_entry_t [3:0] ex;
    logic rv;
    logic brk;
    int miscompares = 0;
    int total_checks = 0;
    always #4 mclk_i = ~mclk_i;
    aphc_core_model core (.mclk_i(mclk_i), .break_i(brk), .emu_run_o(run), .exec_o(exe));
    aphc_top DUT (.mclk_i(mclk_i), .rst_i(rst_i), .emu_run_i(run), .exec_i(exe), .wr_i(wr),
        .ovf_break_sel_i(sel), .rd_i(rd), .rd_all_i(rd_all), .rd_idx_i(idx),
        .rd_entry_o(ent), .rd_all_o(all), .rd_valid_o(rv), .break_o(brk));
    task automatic cmp_e(input aphc_entry_t g, input aphc_entry_t e);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp_e
    task automatic cmp_b(input logic g, input logic e);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp_b
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    // one write, then an idle cycle
    task automatic load(input logic [1:0] i, input logic ag, input logic [14:0] a,
                        input logic cg, input logic [15:0] c);
        wr = {1'b1, i, ag, a, cg, c};
        @(posedge mclk_i);
        #1 wr.valid = 1'b0;
        @(posedge mclk_i);
        #1;
    endtask : load
    // read counter i (and all when a), compare against ex
    task automatic rd_chk(input logic [1:0] i, input logic a);
        idx = i;
        rd_all = a;
        rd = 1'b1;
        @(posedge mclk_i);
        #1 rd = 1'b0;
        cmp_b(rv, 1'b1);
        cmp_e(ent, ex[i]);
        for (int k = 0; k < 4; k++)
            cmp_e(all[k], a ? ex[k] : '0);
        @(posedge mclk_i);
        #1;
    endtask : rd_chk
    // distinct address and preset per counter
    task automatic t_load();
        for (int k = 0; k < 4; k++)
        begin
            ex[k] = {15'h7ffc + 15'(k), 16'h1230 + 16'(k), 1'b0};
            load(2'(k), 1'b1, ex[k].addr, 1'b1, ex[k].count);
            rd_chk(2'(k), 1'b0);
        end
    endtask : t_load
    task automatic t_count();
        core.run(ex[2].addr, 5);
        ex[2].count += 16'h5;
        rd_chk(2'h2, 1'b1);
    endtask : t_count
    // no address and no count given
    task automatic t_keep();
        load(2'h2, 1'b0, 15'h0, 1'b0, 16'hffff);
        ex[2].count = 16'h0;
        rd_chk(2'h2, 1'b0);
    endtask : t_keep
    task automatic t_wrap();
        sel = 1'b1;
        load(2'h1, 1'b0, 15'h0, 1'b1, 16'hffff);
        core.run(ex[1].addr, 2);
        cmp_b(core.broke, 1'b0);
        ex[1].count = 16'h1;
        ex[1].ovf = 1'b1;
        load(2'h0, 1'b0, 15'h0, 1'b1, 16'hffff);
        core.run(ex[0].addr, 3);
        cmp_b(core.broke, 1'b1);
        ex[0].count = 16'h0;
        ex[0].ovf = 1'b1;
        rd_chk(2'h0, 1'b1);
        load(2'h1, 1'b0, 15'h0, 1'b1, 16'h0);
        ex[1] = {ex[1].addr, 16'h0, 1'b0};
        rd_chk(2'h1, 1'b0);
        sel = 1'b0;
        load(2'h0, 1'b0, 15'h0, 1'b1, 16'hffff);
        core.run(ex[0].addr, 2);
        cmp_b(core.broke, 1'b0);
        ex[0].count = 16'h1;
        rd_chk(2'h0, 1'b0);
    endtask : t_wrap
    initial
    begin
        ex = '0;
        repeat (12) @(posedge mclk_i);
        #1 rst_i = 1'b0;
        rd_chk(2'h3, 1'b1);
        t_load();
        t_count();
        t_keep();
        t_wrap();
        finish_test();
    end
    // watchdog
    initial
    begin
        #50us;
        miscompares++;
        finish_test();
    end
endmodule : address_pass_counters_bench
